// file: rtl/csc_defines.svh
// Constants of the clock synthesizer configuration register bank.
// Assumes inclusion by bare name from the register module.
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

`define CSC_SLAVE_ADDR7     7'h69
`define CSC_CMD_BYTE_BIT    7
`define CSC_OFF_FREQ        7'h00
`define CSC_OFF_CPU         7'h01
`define CSC_OFF_PCI         7'h02

`define CSC_F0_UNLOCK_BIT   3
`define CSC_F0_UNLOCK_RST   1'b0
`define CSC_R1_RST          7'h3E
`define CSC_R2_RST          8'h7F

`define CSC_ACK_BIT_COUNT   4'h8

`endif

// file: rtl/csc_pkg.sv
// Types shared by the clock synthesizer configuration register bank.
// Assumes the defines header is on the include path.
package csc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_ADDR   = 4'h1,
    ST_AACK   = 4'h2,
    ST_CMD    = 4'h3,
    ST_CACK   = 4'h4,
    ST_WDATA  = 4'h5,
    ST_WACK   = 4'h6,
    ST_RDATA  = 4'h7,
    ST_RACK   = 4'h8,
    ST_IGNORE = 4'h9
  } csc_state_e;

  typedef struct packed {
    logic       spread_profile_sel;
    logic       spread_enable;
    logic       spread_bw_hi;
    logic       spread_bw_lo;
    logic       chipset_cpu_pair_gate;
    logic       proc_cpu_pair_gate;
    logic       cpu_pair_powerdown_style;
  } csc_cpu_ctrl_s;

  typedef struct packed {
    logic       strength_boost;
    logic       free_clk_gate;
    logic [5:0] other;
  } csc_pci_ctrl_s;

  typedef struct packed {
    logic       cpu_if_mode_strap;
    logic       current_mult_strap;
    logic [3:0] freq_code;
  } csc_strap_s;

endpackage

// file: rtl/csc_regs.sv
// Serial-configured register bank of a clock synthesizer: a two-wire slave
// port doing byte writes and byte reads on three control registers.
// Assumes scl and sda arrive asynchronously and far slower than mclk, and
// that the open-drain wire is resolved outside from sda_o and sda_oe.
`timescale 1ns/1ps
`include "csc_defines.svh"

// Functional notes
// - Byte write: start, address+write, command, data, stop; ack each.
// - Command with top bit one means byte access; low seven bits offset.
// - Byte read: command, repeated start, address+read, one byte, nack.
// - Frequency bits 6:4 and 1 of register 0 writable only when unlocked.
// - Locked: frequency writes ignored, reads return latched straps.
// - Frequency bits power up from the straps as a 4-bit code.
// - Register 0 bit 0 is the read-only latched CPU mode strap.
// - Register 1 bit 7 picks down or center spread, resets zero.
// - Register 1 bit 6 enables spread modulation, resets one.
// - Register 1 bits 5:4 select spread bandwidth, reset to one.
// - Register 1 bits 3 and 2 gate each CPU pair, reset one.
// - Register 1 bit 1 picks CPU power-down style in the first mode only.
// - Register 1 bit 0 is the read-only latched multiplier strap.
// - Register 2 bit 7 selects stronger PCI drive, resets zero.
// - Register 2 bit 6 gates the free-running PCI clock, resets one.
// - Respond only to slave address bytes D2 and D3; ignore other addresses.
// - All registers load defaults at reset; serial access is optional.
module csc_regs (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe,
  input  wire logic                   freq_code_bit0,
  input  wire logic                   freq_code_bit1,
  input  wire logic                   freq_code_bit2,
  input  wire logic                   freq_code_bit3,
  input  wire logic                   cpu_if_mode_strap,
  input  wire logic                   current_mult_strap,
  input  wire logic                   power_down_n,
  output logic [3:0]                  freq_code,
  output csc_pkg::csc_cpu_ctrl_s      cpu_ctrl,
  output csc_pkg::csc_pci_ctrl_s      pci_ctrl,
  output logic                        cpu_pair_pd_drive,
  output logic                        cpu_pair_pd_tristate
);

  // Synchronisers; only the second stage is read by logic.
  logic [8:0]            sync1_q;
  logic [8:0]            sync2_q;
  logic                  scl_d1_q;
  logic                  sda_d1_q;

  // Strap capture and register storage.
  logic                  latch_pend_q;
  csc_pkg::csc_strap_s   strap_q;
  logic [3:0]            freq_sw_q;
  logic                  unlock_q;
  csc_pkg::csc_cpu_ctrl_s cpu_q;
  csc_pkg::csc_pci_ctrl_s pci_q;

  // Serial engine.
  csc_pkg::csc_state_e   state_q;
  csc_pkg::csc_state_e   state_d;
  logic [7:0]            shift_q;
  logic [7:0]            tx_q;
  logic [3:0]            bitcnt_q;
  logic [7:0]            cmd_q;
  logic                  rw_q;
  logic                  oe_q;

  // Output flops.
  logic [3:0]            freq_out_q;
  logic                  pd_drive_q;
  logic                  pd_tri_q;

  wire scl_s = sync2_q[0];
  wire sda_s = sync2_q[1];
  wire scl_rise = scl_s & ~scl_d1_q;
  wire scl_fall = ~scl_s & scl_d1_q;
  wire start_cond = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  wire stop_cond = scl_s & scl_d1_q & ~sda_d1_q & sda_s;
  wire byte_done = (bitcnt_q == `CSC_ACK_BIT_COUNT);

  wire [6:0] offset = cmd_q[6:0];
  wire sel_freq = (offset == `CSC_OFF_FREQ);
  wire sel_cpu = (offset == `CSC_OFF_CPU);
  wire sel_pci = (offset == `CSC_OFF_PCI);

  wire addr_match = (shift_q[7:1] == `CSC_SLAVE_ADDR7);
  wire cmd_is_byte = shift_q[`CSC_CMD_BYTE_BIT];
  wire wr_fire = scl_fall & byte_done & (state_q == csc_pkg::ST_WDATA);
  wire wr_freq = wr_fire & sel_freq;
  wire wr_cpu = wr_fire & sel_cpu;
  wire wr_pci = wr_fire & sel_pci;

  // Locked reads show the straps, unlocked reads the software value.
  wire [3:0] freq_eff = unlock_q ? freq_sw_q : strap_q.freq_code;
  wire [7:0] rd_freq = {1'b0, freq_eff[2:0], unlock_q,
                        strap_q.current_mult_strap, freq_eff[3],
                        strap_q.cpu_if_mode_strap};
  wire [7:0] rd_cpu = {cpu_q, strap_q.current_mult_strap};
  wire [7:0] rd_pci = pci_q;
  wire [7:0] rd_data = sel_freq ? rd_freq :
                       sel_cpu  ? rd_cpu  :
                       sel_pci  ? rd_pci  : 8'h00;

  wire mode_a = strap_q.cpu_if_mode_strap;
  wire pd_low = ~sync2_q[2];

  always_ff @(posedge mclk) begin
    sync1_q <= {current_mult_strap, cpu_if_mode_strap, freq_code_bit3,
                freq_code_bit2, freq_code_bit1, freq_code_bit0,
                power_down_n, sda_i, scl_i};
    sync2_q <= sync1_q;
    scl_d1_q <= sync2_q[0];
    sda_d1_q <= sync2_q[1];
  end

  // Straps are caught in the first cycle after reset release.
  always_ff @(posedge mclk) begin
    if (rst) begin
      latch_pend_q <= 1'b1;
      strap_q <= '0;
    end else if (latch_pend_q) begin
      latch_pend_q <= 1'b0;
      strap_q <= {sync2_q[7], sync2_q[8], sync2_q[6:3]};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      unlock_q <= `CSC_F0_UNLOCK_RST;
    end else if (wr_freq) begin
      unlock_q <= shift_q[`CSC_F0_UNLOCK_BIT];
    end
  end

  // Unlock is judged before the written byte, so the byte that unlocks
  // cannot itself change the frequency code.
  always_ff @(posedge mclk) begin
    if (rst) begin
      freq_sw_q <= '0;
    end else if (latch_pend_q) begin
      freq_sw_q <= sync2_q[6:3];
    end else if (wr_freq && unlock_q) begin
      freq_sw_q <= {shift_q[1], shift_q[6:4]};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_q <= `CSC_R1_RST;
    end else if (wr_cpu) begin
      cpu_q <= shift_q[7:1];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pci_q <= `CSC_R2_RST;
    end else if (wr_pci) begin
      pci_q <= shift_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      freq_out_q <= '0;
      pd_drive_q <= 1'b0;
      pd_tri_q <= 1'b0;
    end else begin
      freq_out_q <= freq_eff;
      pd_drive_q <= mode_a & pd_low & ~cpu_q.cpu_pair_powerdown_style;
      pd_tri_q <= mode_a & pd_low & cpu_q.cpu_pair_powerdown_style;
    end
  end

  always_comb begin
    state_d = state_q;
    if (stop_cond) begin
      state_d = csc_pkg::ST_IDLE;
    end else if (start_cond) begin
      state_d = csc_pkg::ST_ADDR;
    end else if (scl_fall) begin
      case (state_q)
        csc_pkg::ST_ADDR: begin
          if (byte_done) begin
            state_d = addr_match ? csc_pkg::ST_AACK : csc_pkg::ST_IGNORE;
          end
        end
        csc_pkg::ST_AACK: begin
          state_d = rw_q ? csc_pkg::ST_RDATA : csc_pkg::ST_CMD;
        end
        csc_pkg::ST_CMD: begin
          if (byte_done) begin
            state_d = cmd_is_byte ? csc_pkg::ST_CACK : csc_pkg::ST_IGNORE;
          end
        end
        csc_pkg::ST_CACK: begin
          state_d = csc_pkg::ST_WDATA;
        end
        csc_pkg::ST_WDATA: begin
          if (byte_done) begin
            state_d = csc_pkg::ST_WACK;
          end
        end
        csc_pkg::ST_WACK: begin
          state_d = csc_pkg::ST_IGNORE;
        end
        csc_pkg::ST_RDATA: begin
          if (byte_done) begin
            state_d = csc_pkg::ST_RACK;
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end else if (scl_rise && state_q == csc_pkg::ST_RACK) begin
      state_d = csc_pkg::ST_IGNORE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= csc_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Bits are sampled on scl rising edges and driven after falling edges.
  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_q <= '0;
      bitcnt_q <= '0;
    end else if (start_cond || (scl_fall && byte_done)) begin
      bitcnt_q <= '0;
    end else if (scl_fall && state_q == csc_pkg::ST_AACK && rw_q) begin
      bitcnt_q <= 4'h1;
    end else if (scl_fall && state_q == csc_pkg::ST_RDATA) begin
      bitcnt_q <= bitcnt_q + 4'h1;
    end else if (scl_rise && (state_q == csc_pkg::ST_ADDR ||
                 state_q == csc_pkg::ST_CMD ||
                 state_q == csc_pkg::ST_WDATA)) begin
      shift_q <= {shift_q[6:0], sda_s};
      bitcnt_q <= bitcnt_q + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_q <= '0;
      rw_q <= 1'b0;
    end else if (scl_fall && byte_done && state_q == csc_pkg::ST_CMD) begin
      cmd_q <= shift_q;
    end else if (scl_fall && byte_done && state_q == csc_pkg::ST_ADDR) begin
      rw_q <= shift_q[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_q <= '0;
    end else if (scl_fall && state_q == csc_pkg::ST_AACK) begin
      tx_q <= rd_data;
    end else if (scl_fall && state_q == csc_pkg::ST_RDATA) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // Acks pull low; read data releases the line for ones.
  always_ff @(posedge mclk) begin
    if (rst || stop_cond || start_cond) begin
      oe_q <= 1'b0;
    end else if (scl_fall) begin
      case (state_d)
        csc_pkg::ST_AACK,
        csc_pkg::ST_CACK,
        csc_pkg::ST_WACK: begin
          oe_q <= 1'b1;
        end
        csc_pkg::ST_RDATA: begin
          oe_q <= (state_q == csc_pkg::ST_AACK) ? ~rd_data[7] : ~tx_q[6];
        end
        default: begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign freq_code = freq_out_q;
  assign cpu_ctrl = cpu_q;
  assign pci_ctrl = pci_q;
  assign cpu_pair_pd_drive = pd_drive_q;
  assign cpu_pair_pd_tristate = pd_tri_q;

endmodule

// file: testbench/csc_regs_chk_sva.sv
// Port-level checks for the serial-configured clock register bank.
// Assumes it is bound into csc_regs and that scl is far slower than mclk.
`timescale 1ns/1ps
module csc_regs_chk (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   scl_i,
  input wire logic                   sda_o,
  input wire logic                   sda_oe,
  input wire logic                   cpu_if_mode_strap,
  input wire logic [3:0]             freq_code,
  input wire csc_pkg::csc_cpu_ctrl_s cpu_ctrl,
  input wire csc_pkg::csc_pci_ctrl_s pci_ctrl,
  input wire logic                   cpu_pair_pd_drive,
  input wire logic                   cpu_pair_pd_tristate
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);

  reset_vals_a: assert property (disable iff (1'b0) rst |=>
    !sda_oe && cpu_ctrl == 7'h3E && pci_ctrl == 8'h7F && freq_code == 4'h0)
    else $error("reset values wrong");
  ack_timing_a: assert property ($changed(sda_oe) |->
    !$past(scl_i) && $past(scl_i, 6)) else $error("sda drive mistimed");
  sda_zero_a: assert property (sda_oe |-> !sda_o)
    else $error("open drain drives high");
  cpu_update_a: assert property ($changed(cpu_ctrl) |->
    sda_oe && !$past(sda_oe, 2)) else $error("cpu control changed late");
  pci_update_a: assert property ($changed(pci_ctrl) |->
    sda_oe && !$past(sda_oe, 2)) else $error("pci control changed late");
  freq_hold_a: assert property ($changed(freq_code) |-> sda_oe ||
    $past(rst, 2) || $past(rst, 3) || $past(rst, 4))
    else $error("frequency code moved without a write");
  pd_excl_a: assert property (!(cpu_pair_pd_drive && cpu_pair_pd_tristate))
    else $error("both power-down styles active");
  // Settled style only: the style bit and the pd outputs may skew by a cycle.
  pd_drive_a: assert property (cpu_pair_pd_drive &&
    cpu_ctrl == $past(cpu_ctrl) && cpu_ctrl == $past(cpu_ctrl, 2) |->
    !cpu_ctrl.cpu_pair_powerdown_style && cpu_if_mode_strap)
    else $error("drive style without cause");
  pd_tri_a: assert property (cpu_pair_pd_tristate &&
    cpu_ctrl == $past(cpu_ctrl) && cpu_ctrl == $past(cpu_ctrl, 2) |->
    cpu_ctrl.cpu_pair_powerdown_style && cpu_if_mode_strap)
    else $error("tristate style without cause");

  cover property ($rose(sda_oe));
  cover property (cpu_pair_pd_drive);
  cover property (cpu_pair_pd_tristate);
endmodule

bind csc_regs csc_regs_chk i_csc_regs_chk (.mclk, .rst, .scl_i, .sda_o,
  .sda_oe, .cpu_if_mode_strap, .freq_code, .cpu_ctrl, .pci_ctrl,
  .cpu_pair_pd_drive, .cpu_pair_pd_tristate);

// file: testbench/csc_host.sv
// Two-wire host model doing byte writes and byte reads, 64 ns bit time.
// Assumes the bench resolves the open-drain wire with a pull-up into sda_w.
`timescale 1ns/1ps
module csc_host (
  output logic      scl,
  output logic      sda,
  input  wire logic sda_w
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic clk_bit(input logic b, output logic s);
    #16 sda = b;
    #16 scl = 1'b1;
    #28 s = sda_w;
    #4 scl = 1'b0;
  endtask

  task automatic start;
    #16 sda = 1'b1;
    #16 scl = 1'b1;
    #16 sda = 1'b0;
    #16 scl = 1'b0;
  endtask

  task automatic stop;
    #16 sda = 1'b0;
    #16 scl = 1'b1;
    #16 sda = 1'b1;
    #16;
  endtask

  task automatic put_byte(input logic [7:0] d, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    ok = ok & ~s;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] c,
                    input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    put_byte(a, ok);
    put_byte(c, ok);
    put_byte(d, ok);
    stop();
  endtask

  task automatic rd(input logic [7:0] c, output logic [7:0] d,
                    output logic ok);
    logic s;
    ok = 1'b1;
    start();
    put_byte(8'hD2, ok);
    put_byte(c, ok);
    start();
    put_byte(8'hD3, ok);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(1'b1, s);
    stop();
  endtask
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the clock register bank over its two-wire port.
// Assumes csc_host as the far side; all pins move 1 ns after mclk rises.
`timescale 1ns/1ps
module testbench;
  logic                   mclk, rst, power_down_n, mode_s, mult_s;
  logic                   sda_o, sda_oe, pd_drv, pd_tri, scl, host_sda, ok;
  logic [3:0]             strap_code, freq_code;
  logic [7:0]             rdat;
  csc_pkg::csc_cpu_ctrl_s cpu_ctrl;
  csc_pkg::csc_pci_ctrl_s pci_ctrl;
  int                     err_total, checks;
  wire logic              sda_w = host_sda & ~(sda_oe & ~sda_o);

  csc_host i_csc_host (.scl(scl), .sda(host_sda), .sda_w(sda_w));
  csc_regs i_csc_regs (.mclk(mclk), .rst(rst), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .freq_code_bit0(strap_code[0]),
    .freq_code_bit1(strap_code[1]), .freq_code_bit2(strap_code[2]),
    .freq_code_bit3(strap_code[3]), .cpu_if_mode_strap(mode_s),
    .current_mult_strap(mult_s), .power_down_n(power_down_n),
    .freq_code(freq_code), .cpu_ctrl(cpu_ctrl), .pci_ctrl(pci_ctrl),
    .cpu_pair_pd_drive(pd_drv), .cpu_pair_pd_tristate(pd_tri));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic w(input logic [7:0] a, c, d, input logic exp_ok);
    i_csc_host.wr(a, c, d, ok);
    chk({7'h00, ok}, {7'h00, exp_ok});
  endtask

  task automatic r(input logic [7:0] c, input logic [7:0] exp);
    i_csc_host.rd(c, rdat, ok);
    chk({7'h00, ok}, 8'h01);
    chk(rdat, exp);
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Generous: the whole sequence needs about a quarter of this.
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    power_down_n = 1'b1;
    strap_code = 4'hA;
    mode_s = 1'b1;
    mult_s = 1'b0;
    repeat (6) @(posedge mclk);
    #1 rst = 1'b0;
    #80;
    chk({1'b0, cpu_ctrl}, 8'h3E);
    chk(pci_ctrl, 8'h7F);
    chk({4'h0, freq_code}, 8'h0A);
    r(8'h80, 8'h23);
    r(8'h81, 8'h7C);
    r(8'h82, 8'h7F);
    w(8'hD2, 8'h80, 8'h72, 1'b1);
    chk({4'h0, freq_code}, 8'h0A);
    w(8'hD2, 8'h80, 8'h08, 1'b1);
    w(8'hD2, 8'h80, 8'h58, 1'b1);
    chk({4'h0, freq_code}, 8'h05);
    r(8'h80, 8'h59);
    w(8'hD2, 8'h80, 8'h50, 1'b1);
    chk({4'h0, freq_code}, 8'h0A);
    r(8'h80, 8'h23);
    w(8'hD2, 8'h81, 8'h81, 1'b1);
    chk({1'b0, cpu_ctrl}, 8'h40);
    r(8'h81, 8'h80);
    w(8'hD2, 8'h81, 8'h7E, 1'b1);
    chk({1'b0, cpu_ctrl}, 8'h3F);
    power_down_n = 1'b0;
    #80 chk({6'h00, pd_drv, pd_tri}, 8'h01);
    w(8'hD2, 8'h81, 8'h3C, 1'b1);
    #80 chk({6'h00, pd_drv, pd_tri}, 8'h02);
    power_down_n = 1'b1;
    #80 chk({6'h00, pd_drv, pd_tri}, 8'h00);
    w(8'hD2, 8'h82, 8'hA0, 1'b1);
    r(8'h82, 8'hA0);
    w(8'hD4, 8'h82, 8'h7F, 1'b0);
    w(8'hD2, 8'h02, 8'h7F, 1'b0);
    w(8'hD2, 8'h85, 8'hFF, 1'b1);
    r(8'h85, 8'h00);
    chk(pci_ctrl, 8'hA0);
    chk({1'b0, cpu_ctrl}, 8'h1E);
    strap_code = 4'h5;
    mode_s = 1'b0;
    mult_s = 1'b1;
    power_down_n = 1'b0;
    rst = 1'b1;
    #48 rst = 1'b0;
    #80 chk({4'h0, freq_code}, 8'h05);
    chk({6'h00, pd_drv, pd_tri}, 8'h00);
    r(8'h80, 8'h54);
    r(8'h81, 8'h7D);
    report_and_stop();
  end
endmodule
